// >>> logic/sync_pkg.sv
// Function
// - modulation clock is system clock, undivided
// - modulation clock driven out to modulators
// - external bit-streams feed sinc3 filters directly
// - oversampling ratio 1024 for filters and trigger
// - filters and trigger start and output together
// - keep one filter output in five
// - trigger pulses at full decimated rate
// - voltage converter armed once per ten triggers (every second kept trigger)
// - accepted trigger scans six channels once
// - 4 MHz converter clock, 8 sample, 12 convert
// - format select 1 gives 16-bit signed results
// - scan maps A10 temperature, A5/A4/A3 phase voltages
// - bit-streams 0,1,2 feed phase A,B,C filters
// - pin mapping of clock out and bit-streams
// - transfer engine stores results, flags after six
// - trigger keeps conversion sampling instants synchronized
package sync_pkg;
  localparam longint CLK_HZ = 200000000;
  localparam longint MOD_CLK_HZ = CLK_HZ;
  localparam longint SAR_CLK_HZ = 4000000;
  localparam int SAR_DIV = int'(CLK_HZ / SAR_CLK_HZ);
  localparam int OSR = 1024;
  localparam int SKIP_RATIO = 5;
  localparam int SAR_SAMPLE_CYCLES = 8;
  localparam int SAR_CONV_CYCLES = 12;
  localparam int SCAN_LEN = 6;
  localparam int PHASES = 3;
  localparam int FILT_W = 31;
  localparam int RESULT_W = 10;
  localparam int SIGNED_PAD = 6;
  // scan order: temperature, phase voltages 1..3, two spares
  localparam logic [3:0] SCAN_CHAN [SCAN_LEN] =
    '{4'ha, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1};
  localparam logic [7:0] CTRL_OFFS = 8'h00;
  localparam logic [7:0] STATUS_OFFS = 8'h04;
  localparam logic [7:0] KEPT_COUNT_OFFS = 8'h08;
  localparam logic [7:0] CURRENT_BASE = 8'h10;
  localparam logic [7:0] VOLTAGE_BASE = 8'h20;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_FORMAT_BIT = 1;
  localparam int STATUS_DONE_BIT = 0;
  localparam int STATUS_BUSY_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_CONVERT} sar_state_type;
endpackage

// >>> logic/sinc3_decimator.sv
`timescale 1ns/100ps
module sinc3_decimator
  import sync_pkg::*;
#(
  parameter int W = FILT_W
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic enable,
  input wire logic bit_in,
  input wire logic dump,
  output logic [W-1:0] data_out,
  output logic data_valid
);
  logic [W-1:0] int1_reg, int2_reg, int3_reg;
  logic [W-1:0] z1_reg, z2_reg, z3_reg;
  logic [W-1:0] d1, d2, d3;

  // modular wrap of the integrators is harmless for sinc3
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      int1_reg <= '0;
      int2_reg <= '0;
      int3_reg <= '0;
    end
    else if (!enable)
    begin
      int1_reg <= '0;
      int2_reg <= '0;
      int3_reg <= '0;
    end
    else
    begin
      int1_reg <= int1_reg + W'(bit_in);
      int2_reg <= int2_reg + int1_reg;
      int3_reg <= int3_reg + int2_reg;
    end
  end

  always_comb
  begin
    d1 = int3_reg - z1_reg;
    d2 = d1 - z2_reg;
    d3 = d2 - z3_reg;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      z1_reg <= '0;
      z2_reg <= '0;
      z3_reg <= '0;
      data_out <= '0;
      data_valid <= 1'b0;
    end
    else if (!enable)
    begin
      z1_reg <= '0;
      z2_reg <= '0;
      z3_reg <= '0;
      data_valid <= 1'b0;
    end
    else
    begin
      data_valid <= dump;
      if (dump)
      begin
        z1_reg <= int3_reg;
        z2_reg <= d1;
        z3_reg <= d2;
        data_out <= d3;
      end
    end
  end
endmodule

// >>> logic/polyphase_sample_synchronizer.sv
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module polyphase_sample_synchronizer
  import sync_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic bitstream_in_0,
  input wire logic bitstream_in_1,
  input wire logic bitstream_in_2,
  output logic modulation_clock_out,
  output logic [3:0] sar_channel_sel,
  output logic sar_sample_hold,
  input wire logic [9:0] sar_sample_data,
  output logic trigger_pulse,
  output logic kept_sample,
  output logic transfer_done_flag
);
  logic [1:0] ctrl_reg;
  logic group_en;
  logic format_sel;
  logic [9:0] decim_cnt_reg;
  logic dump;
  logic [2:0] skip_cnt_reg;
  logic kept_now;
  logic [31:0] kept_count_reg;
  logic [PHASES-1:0] bits;
  logic [FILT_W-1:0] filt_data [PHASES];
  logic [PHASES-1:0] filt_valid;
  logic [FILT_W-1:0] current_reg [PHASES];
  logic [5:0] sar_div_reg;
  logic sar_tick;
  sar_state_type sar_state_reg;
  logic [4:0] phase_reg;
  logic [2:0] chan_idx_reg;
  logic [9:0] held_reg;
  logic [15:0] sar_result_reg;
  logic [2:0] sar_result_idx_reg;
  logic sar_result_valid_reg;
  logic [15:0] volt_reg [SCAN_LEN];
  logic done_set;
  logic done_clr;

  assign group_en = ctrl_reg[CTRL_ENABLE_BIT];
  assign format_sel = ctrl_reg[CTRL_FORMAT_BIT];

  // forwarded clock, so the modulators run at the filter rate
  assign modulation_clock_out = clk;
  assign bits = {bitstream_in_2, bitstream_in_1, bitstream_in_0};

  // one decimation count shared by all filters and the trigger
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      decim_cnt_reg <= '0;
    else if (!group_en)
      decim_cnt_reg <= '0;
    else
      decim_cnt_reg <= decim_cnt_reg + 10'h001;
  end

  assign dump = group_en && (decim_cnt_reg == 10'(OSR - 1));

  genvar g;
  generate
    for (g = 0; g < PHASES; g++)
    begin : g_filt
      sinc3_decimator #(
        .W(FILT_W)
      ) u_filt (
        .clk(clk),
        .arst_n(arst_n),
        .enable(group_en),
        .bit_in(bits[g]),
        .dump(dump),
        .data_out(filt_data[g]),
        .data_valid(filt_valid[g])
      );
    end
  endgenerate

  // trigger lands on the same cycle as the filter outputs
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      trigger_pulse <= 1'b0;
    else
      trigger_pulse <= dump;
  end

  assign kept_now = trigger_pulse && (skip_cnt_reg == 3'h0);
  assign kept_sample = kept_now;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      skip_cnt_reg <= '0;
    else if (!group_en)
      skip_cnt_reg <= '0;
    else if (trigger_pulse)
      skip_cnt_reg <= (skip_cnt_reg == 3'(SKIP_RATIO - 1)) ?
        3'h0 : skip_cnt_reg + 3'h1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      kept_count_reg <= '0;
    else if (kept_now)
      kept_count_reg <= kept_count_reg + 32'h1;
  end

  // skipped outputs never reach the current registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < PHASES; i++)
        current_reg[i] <= '0;
    end
    else if (kept_now)
    begin
      for (int i = 0; i < PHASES; i++)
        current_reg[i] <= filt_data[i];
    end
  end

  // 4 MHz enable; free running, so the first tick of a scan comes 1 to 50 cycles after arming
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sar_div_reg <= '0;
    else if (sar_div_reg == 6'(SAR_DIV - 1))
      sar_div_reg <= '0;
    else
      sar_div_reg <= sar_div_reg + 6'h01;
  end

  assign sar_tick = (sar_div_reg == 6'(SAR_DIV - 1));

  // a kept trigger during a running scan is dropped, not queued
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sar_state_reg <= SAR_IDLE;
      phase_reg <= '0;
      chan_idx_reg <= '0;
    end
    else
    begin
      unique case (sar_state_reg)
        SAR_IDLE:
          if (kept_now)
          begin
            sar_state_reg <= SAR_SAMPLE;
            phase_reg <= '0;
            chan_idx_reg <= '0;
          end
        SAR_SAMPLE:
          if (sar_tick)
          begin
            if (phase_reg == 5'(SAR_SAMPLE_CYCLES - 1))
            begin
              sar_state_reg <= SAR_CONVERT;
              phase_reg <= '0;
            end
            else
              phase_reg <= phase_reg + 5'h01;
          end
        SAR_CONVERT:
          if (sar_tick)
          begin
            if (phase_reg == 5'(SAR_CONV_CYCLES - 1))
            begin
              phase_reg <= '0;
              if (chan_idx_reg == 3'(SCAN_LEN - 1))
                sar_state_reg <= SAR_IDLE;
              else
              begin
                sar_state_reg <= SAR_SAMPLE;
                chan_idx_reg <= chan_idx_reg + 3'h1;
              end
            end
            else
              phase_reg <= phase_reg + 5'h01;
          end
      endcase
    end
  end

  assign sar_channel_sel = SCAN_CHAN[chan_idx_reg];
  assign sar_sample_hold = (sar_state_reg == SAR_SAMPLE);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      held_reg <= '0;
    else if (sar_state_reg == SAR_SAMPLE && sar_tick &&
             phase_reg == 5'(SAR_SAMPLE_CYCLES - 1))
      held_reg <= sar_sample_data;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sar_result_reg <= '0;
      sar_result_idx_reg <= '0;
      sar_result_valid_reg <= 1'b0;
    end
    else
    begin
      sar_result_valid_reg <= 1'b0;
      if (sar_state_reg == SAR_CONVERT && sar_tick &&
          phase_reg == 5'(SAR_CONV_CYCLES - 1))
      begin
        sar_result_valid_reg <= 1'b1;
        sar_result_idx_reg <= chan_idx_reg;
        // offset binary to signed, left justified
        if (format_sel)
          sar_result_reg <= {~held_reg[9], held_reg[8:0],
            SIGNED_PAD'(0)};
        else
          sar_result_reg <= {SIGNED_PAD'(0), held_reg};
      end
    end
  end

  // transfer engine: one store per result, flag after the sixth
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < SCAN_LEN; i++)
        volt_reg[i] <= '0;
    end
    else if (sar_result_valid_reg)
      volt_reg[sar_result_idx_reg] <= sar_result_reg;
  end

  assign done_set = sar_result_valid_reg &&
    (sar_result_idx_reg == 3'(SCAN_LEN - 1));
  assign done_clr = reg_write && reg_addr == STATUS_OFFS &&
    reg_wdata[STATUS_DONE_BIT];

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      transfer_done_flag <= 1'b0;
    else if (done_set)
      transfer_done_flag <= 1'b1;
    else if (done_clr)
      transfer_done_flag <= 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ctrl_reg <= CTRL_RESET;
    else if (reg_write && reg_addr == CTRL_OFFS)
      ctrl_reg <= reg_wdata[1:0];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= '0;
    else if (!reg_read)
      reg_rdata <= '0;
    else if (reg_addr == CTRL_OFFS)
      reg_rdata <= {30'h0, ctrl_reg};
    else if (reg_addr == STATUS_OFFS)
      reg_rdata <= {25'h0, skip_cnt_reg, 2'h0,
        sar_state_reg != SAR_IDLE, transfer_done_flag};
    else if (reg_addr == KEPT_COUNT_OFFS)
      reg_rdata <= kept_count_reg;
    else if (reg_addr >= CURRENT_BASE && reg_addr < 8'(CURRENT_BASE + 4 *
             PHASES) && reg_addr[1:0] == 2'h0)
      reg_rdata <= {1'b0, current_reg[2'(reg_addr[3:2])]};
    else if (reg_addr >= VOLTAGE_BASE && reg_addr < 8'(VOLTAGE_BASE + 4 *
             SCAN_LEN) && reg_addr[1:0] == 2'h0)
      reg_rdata <= {16'h0, volt_reg[3'(reg_addr[4:2])]};
    else
      reg_rdata <= '0;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  logic [12:0] scan_age_reg;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      scan_age_reg <= '0;
    else if (sar_state_reg == SAR_IDLE)
      scan_age_reg <= '0;
    else
      scan_age_reg <= scan_age_reg + 13'h1;
  end

  trig_spacing_a: assert property (trigger_pulse |=> !trigger_pulse [*8])
    else $error("trigger pulses too close");
  trig_follows_dump_a: assert property (dump |=> trigger_pulse)
    else $error("trigger missing after filter dump");
  filt_grouped_a: assert property (trigger_pulse == filt_valid[0] &&
    filt_valid[0] == filt_valid[1] && filt_valid[1] == filt_valid[2])
    else $error("filter outputs not grouped with trigger");
  skip_range_a: assert property (skip_cnt_reg < 3'(SKIP_RATIO))
    else $error("skip counter out of range");
  kept_wrap_a: assert property (trigger_pulse && skip_cnt_reg == 3'h4
    |=> skip_cnt_reg == 3'h0)
    else $error("kept counter failed to wrap");
  arm_on_kept_a: assert property (sar_state_reg == SAR_IDLE && kept_now
    |=> sar_state_reg == SAR_SAMPLE && chan_idx_reg == 3'h0)
    else $error("converter not armed on kept trigger");
  no_arm_skip_a: assert property (sar_state_reg == SAR_IDLE && !kept_now
    |=> sar_state_reg == SAR_IDLE)
    else $error("converter armed without kept trigger");
  scan_length_a: assert property (scan_age_reg <= 13'(SAR_DIV *
    SCAN_LEN * (SAR_SAMPLE_CYCLES + SAR_CONV_CYCLES)))
    else $error("scan longer than six channels");
  format_sign_a: assert property (sar_result_valid_reg && format_sel
    |-> sar_result_reg[5:0] == 6'h0)
    else $error("signed result not left justified");
  done_after_six_a: assert property (done_set |=> transfer_done_flag)
    else $error("transfer done flag not set");
  done_set_wins_a: assert property (done_set && done_clr
    |=> transfer_done_flag)
    else $error("flag clear beat a new completion");

  kept_cov: cover property (kept_now);
  scan_done_cov: cover property (done_set);
  drop_cov: cover property (kept_now && sar_state_reg != SAR_IDLE);
endmodule

// >>> tb/modulator_model.sv
`timescale 1ns/100ps
module modulator_model
(
  input wire logic mod_clk,
  output logic [2:0] bits
);
  // fixed densities keep the expected filter ordering obvious: 1 > 0.5 > 0
  initial bits = 3'h1;
  always @(posedge mod_clk)
  begin
    bits[0] <= 1'b1;
    bits[1] <= 1'b0;
    bits[2] <= ~bits[2];
  end
endmodule

// >>> tb/tb_polyphase_sample_synchronizer.sv
`timescale 1ns/100ps
module tb_polyphase_sample_synchronizer
  import sync_pkg::*;
;
  logic clk, arst_n, reg_write, reg_read;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d, ia, ib, ic;
  logic [9:0] sar_sample_data;
  logic [2:0] bits;
  logic modulation_clock_out, sar_sample_hold, trigger_pulse, kept_sample;
  logic transfer_done_flag, sh_prev;
  logic [3:0] sar_channel_sel;
  int n_errors, checks, ntrig, last_trig, first_trig, cyc, ci, hold_len, t0;

  polyphase_sample_synchronizer u_polyphase_sample_synchronizer (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .bitstream_in_0(bits[0]), .bitstream_in_1(bits[1]),
    .bitstream_in_2(bits[2]), .modulation_clock_out(modulation_clock_out),
    .sar_channel_sel(sar_channel_sel), .sar_sample_hold(sar_sample_hold),
    .sar_sample_data(sar_sample_data), .trigger_pulse(trigger_pulse),
    .kept_sample(kept_sample), .transfer_done_flag(transfer_done_flag)
  );
  modulator_model u_modulator_model (
    .mod_clk(modulation_clock_out), .bits(bits)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic close_out();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  // data stands only in the cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic wait_done(input int bound);
    int i;
    for (i = 0; i < bound && transfer_done_flag !== 1'b1; i++)
      @(posedge clk);
    if (i == bound)
    begin
      n_errors++;
      close_out();
    end
  endtask

  function automatic logic [15:0] exp_v(input logic [3:0] ch, input logic f);
    logic [9:0] s;
    s = {ch, 6'h2a};
    exp_v = f ? {~s[9], s[8:0], 6'h00} : {6'h00, s};
  endfunction

  task automatic check_volts(input logic f);
    for (int i = 0; i < SCAN_LEN; i++)
    begin
      rd(VOLTAGE_BASE + 8'(4 * i), d);
      check("volt", d, {16'h0, exp_v(SCAN_CHAN[i], f)});
    end
  endtask

  // analog stand-in: value tells which channel was sampled
  always @(posedge clk)
    sar_sample_data <= {sar_channel_sel, 6'h2a};

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    sh_prev <= sar_sample_hold;
    if (arst_n === 1'b1)
    begin
      if (trigger_pulse === 1'b1)
      begin
        if (ntrig == 0)
          first_trig = cyc;
        else
          check("trig gap", cyc - last_trig, OSR);
        check("kept", kept_sample, ntrig % SKIP_RATIO == 0);
        last_trig = cyc;
        ntrig++;
      end
      else
        check("kept idle", kept_sample, 0);
      if (sar_sample_hold === 1'b1 && sh_prev === 1'b0)
      begin
        check("chan", sar_channel_sel, SCAN_CHAN[ci % SCAN_LEN]);
        ci++;
        hold_len = 0;
      end
      if (sar_sample_hold === 1'b1)
        hold_len++;
      if (sar_sample_hold === 1'b0 && sh_prev === 1'b1)
        check("hold", hold_len > 350 && hold_len <= 400, 1);
    end
  end

  initial
  begin
    {reg_write, reg_read, reg_addr, reg_wdata} = '0;
    {n_errors, checks, ntrig, last_trig, first_trig, cyc, ci, hold_len} = '0;
    sh_prev = 1'b0;
    sar_sample_data = '0;
    arst_n = 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    rd(CTRL_OFFS, d);
    check("ctrl", d, {30'h0, CTRL_RESET});
    rd(8'h40, d);
    check("unmapped", d, 0);
    rd(STATUS_OFFS, d);
    check("status", d, 0);
    check("done", transfer_done_flag, 0);
    repeat (1100) @(posedge clk);
    check("idle trig", ntrig, 0);
    @(posedge clk) #1;
    check("mclk hi", modulation_clock_out, 1);
    @(negedge clk) #1;
    check("mclk lo", modulation_clock_out, 0);
    wr(CTRL_OFFS, 32'h3);
    #1 t0 = cyc;
    wait_done(8000);
    check("first trig", first_trig - t0 >= 1020 && first_trig - t0 <= 1028,
          1);
    check("done set", transfer_done_flag, 1);
    // six triggers seen, second kept one dropped: skip count 1, idle, done
    rd(STATUS_OFFS, d);
    check("status done", d, 32'h11);
    check_volts(1'b1);
    rd(CURRENT_BASE, ia);
    rd(CURRENT_BASE + 8'h04, ib);
    rd(CURRENT_BASE + 8'h08, ic);
    check("cur b", ib, 0);
    check("cur a gt c", ia > ic && ic > ib, 1);
    wr(STATUS_OFFS, 32'h1);
    @(posedge clk) #1;
    check("done clr", transfer_done_flag, 0);
    wr(CTRL_OFFS, 32'h1);
    wait_done(20000);
    check_volts(1'b0);
    check("chan count", ci, 2 * SCAN_LEN);
    check("trig count", ntrig >= 10, 1);
    rd(KEPT_COUNT_OFFS, d);
    check("kept count", d, (ntrig + SKIP_RATIO - 1) / SKIP_RATIO);
    close_out();
  end
endmodule
